/* File: include/dpev_pkg.sv */
// Purpose: Shared constants, types and helpers for the playback effects and volume path.
// Assumes: One 200 MHz clock, synchronous active-high reset.
// Notes: The rules of operation follow; code carries their tags.
package dpev_pkg;
  // Sample and coefficient widths.
  localparam int DW = 16;
  localparam int CW = 16;
  typedef logic signed [DW-1:0] dpev_smp_t;
  typedef logic signed [CW-1:0] dpev_coef_t;
  // Coefficient store: 16 slots per channel, left first.
  localparam int NCOEF = 32;
  localparam int COEF_CH = 16;
  localparam logic [4:0] K_DE_N0 = 5'h00;
  localparam logic [4:0] K_DE_N1 = 5'h01;
  localparam logic [4:0] K_DE_D1 = 5'h02;
  localparam logic [4:0] K_B1_N0 = 5'h03;
  localparam logic [4:0] K_B1_N1 = 5'h04;
  localparam logic [4:0] K_B1_N2 = 5'h05;
  localparam logic [4:0] K_B1_D1 = 5'h06;
  localparam logic [4:0] K_B1_D2 = 5'h07;
  localparam logic [4:0] K_B2_N3 = 5'h08;
  localparam logic [4:0] K_B2_N4 = 5'h09;
  localparam logic [4:0] K_B2_N5 = 5'h0A;
  localparam logic [4:0] K_B2_D4 = 5'h0B;
  localparam logic [4:0] K_B2_D5 = 5'h0C;
  // Reset coefficient values.
  localparam dpev_coef_t DE_N0_RST = 16'sd14677;
  localparam dpev_coef_t DE_N1_RST = -16'sd3283;
  localparam dpev_coef_t DE_D1_RST = 16'sd21374;
  localparam dpev_coef_t EQ_N0_RST = 16'sd27619;
  localparam dpev_coef_t EQ_N1_RST = -16'sd27034;
  localparam dpev_coef_t EQ_N2_RST = 16'sd26461;
  localparam dpev_coef_t EQ_D1_RST = 16'sd32131;
  localparam dpev_coef_t EQ_D2_RST = -16'sd31506;
  // Filter scaling: denominator constant 32768 is a shift by 15.
  localparam int COEF_SH = 15;
  // Volume: 0.5 dB per index, 127 is -63.5 dB, 128 means silence.
  localparam logic [7:0] MUTE_IDX = 8'h80;
  localparam logic [7:0] STEPS_OCT = 8'h0C;
  // Output path timing.
  localparam int DLY = 21;
  localparam int OSR = 128;
  localparam int SYS_HZ = 200_000_000;
  localparam int REF_HZ = 48_000;
  localparam int OUT_DIV_CYC = SYS_HZ / (OSR * REF_HZ);
  localparam int SMOOTH_SH = 2;
  // Host register byte offsets.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_VOL = 5'h04;
  localparam logic [4:0] REG_COEF = 5'h08;
  localparam logic [4:0] REG_SAMPLE = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  // Control register fields.
  localparam int CB_DEEMPH = 0;
  localparam int CB_EFF = 1;
  localparam int CB_3D = 2;
  localparam int CB_SOFTOFF = 3;
  localparam int CB_SLOW = 4;
  localparam int CB_POWER = 5;
  localparam int CB_MUTEL = 6;
  localparam int CB_MUTER = 7;
  localparam int CB_ATT = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Clamps a wide signed value to the sample range.
  function automatic dpev_smp_t dpev_sat(input logic signed [39:0] v);
    if (v > 40'sd32767) return 16'sh7FFF;
    else if (v < -40'sd32768) return 16'sh8000;
    else return v[DW-1:0];
  endfunction : dpev_sat

  // Gives the reset value of one coefficient slot.
  function automatic dpev_coef_t dpev_coef_rst(input logic [4:0] a);
    logic [4:0] k;
    k = {1'b0, a[3:0]};
    if (k == K_DE_N0) return DE_N0_RST;
    else if (k == K_DE_N1) return DE_N1_RST;
    else if (k == K_DE_D1) return DE_D1_RST;
    else if (k == K_B1_N0 || k == K_B2_N3) return EQ_N0_RST;
    else if (k == K_B1_N1 || k == K_B2_N4) return EQ_N1_RST;
    else if (k == K_B1_N2 || k == K_B2_N5) return EQ_N2_RST;
    else if (k == K_B1_D1 || k == K_B2_D4) return EQ_D1_RST;
    else if (k == K_B1_D2 || k == K_B2_D5) return EQ_D2_RST;
    else return '0;
  endfunction : dpev_coef_rst
endpackage : dpev_pkg

/* File: include/dpev_if.sv */
// Purpose: Link between the host controller and the playback path.
// Assumes: Both ends run on the same sys_clk.
// Notes: Strobes are one-cycle pulses, settings are levels.
`timescale 1ns/1ps
interface dpev_if;
  import dpev_pkg::*;
  logic en_deemph; // De-emphasis requested.
  logic en_eff; // Effects biquads requested.
  logic en_3d; // 3D mode requested.
  logic [7:0] att_3d; // 3D level, gain is value over 256.
  logic soft_off; // Volume changes jump at once.
  logic slow_step; // One volume step per two samples.
  logic dac_power; // Playback path powered.
  logic mute_l; // Left mute.
  logic mute_r; // Right mute.
  logic smp_valid; // New stereo sample pulse.
  dpev_smp_t smp_l; // Left sample.
  dpev_smp_t smp_r; // Right sample.
  logic coef_wr; // Coefficient write pulse.
  logic [4:0] coef_addr; // Coefficient slot.
  dpev_coef_t coef_data; // Coefficient value.
  logic vol_wr; // Volume write pulse.
  logic [1:0] vol_sel; // Bit 0 left, bit 1 right, both is master.
  logic [6:0] vol_val; // Attenuation in 0.5 dB steps.
  logic vol_done; // Applied volume equals target.
  logic pwr_down_done; // Powered off and fully muted.
  modport dev (
    input en_deemph, en_eff, en_3d, att_3d, soft_off, slow_step, dac_power,
    input mute_l, mute_r, smp_valid, smp_l, smp_r, coef_wr, coef_addr,
    input coef_data, vol_wr, vol_sel, vol_val,
    output vol_done, pwr_down_done
  );
  modport host (
    output en_deemph, en_eff, en_3d, att_3d, soft_off, slow_step, dac_power,
    output mute_l, mute_r, smp_valid, smp_l, smp_r, coef_wr, coef_addr,
    output coef_data, vol_wr, vol_sel, vol_val,
    input vol_done, pwr_down_done
  );
endinterface : dpev_if

/* File: design/dpev_sos.sv */
// Purpose: One second-order recursive section, also used as first-order.
// Assumes: Sample strobe is sparse; the sum settles within one cycle.
// Notes: Output is combinational from x and the held history.
`timescale 1ns/1ps
module dpev_sos (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smp,
  input wire logic clr,
  input wire logic dbl,
  input wire dpev_pkg::dpev_smp_t x,
  input wire dpev_pkg::dpev_coef_t n0,
  input wire dpev_pkg::dpev_coef_t n1,
  input wire dpev_pkg::dpev_coef_t n2,
  input wire dpev_pkg::dpev_coef_t d1,
  input wire dpev_pkg::dpev_coef_t d2,
  output dpev_pkg::dpev_smp_t y
);
  import dpev_pkg::*;
  dpev_smp_t x1_q, x2_q, y1_q, y2_q; // Input and output history.
  logic signed [39:0] acc; // Full-precision sum.

  // Middle terms are doubled in biquad use; the 32768 constant is the shift.
  assign acc = 40'(n0 * x) + (40'(n1 * x1_q) <<< dbl) + 40'(n2 * x2_q)
             + (40'(d1 * y1_q) <<< dbl) + 40'(d2 * y2_q);
  assign y = dpev_sat(acc >>> COEF_SH);

  // History shifts on each sample and clears when processing is switched.
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      x1_q <= '0;
      x2_q <= '0;
      y1_q <= '0;
      y2_q <= '0;
    end else if (smp) begin
      x1_q <= x;
      x2_q <= x1_q;
      y1_q <= y;
      y2_q <= y1_q;
    end
  end
endmodule : dpev_sos

/* File: design/dpev_dev.sv */
// Purpose: Playback path: de-emphasis, effects, 3D, volume, upsampled output.
// Assumes: Samples and settings arrive on the link in the sys_clk domain.
// Notes: The output stream ticks at 128 times the reference rate.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dpev_dev #(
  parameter int OUT_DIV = dpev_pkg::OUT_DIV_CYC // Cycles per output tick.
) (
  dpev_if.dev lnk,
  input wire logic sys_clk,
  input wire logic rst,
  output logic dac_valid,
  output dpev_pkg::dpev_smp_t dac_l,
  output dpev_pkg::dpev_smp_t dac_r
);
  import dpev_pkg::*;

  // Processing switch sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FADE = 3'b010,
    ST_APPLY = 3'b100
  } dpev_st_e;

  // Scales a sample by a 0.5 dB step index; 128 and above is silence.
  function automatic dpev_smp_t vol_apply(input dpev_smp_t x, input logic [7:0] idx);
    logic [7:0] oct;
    logic [7:0] fr;
    logic signed [16:0] g;
    logic signed [33:0] p;
    oct = idx / STEPS_OCT;
    fr = idx % STEPS_OCT;
    case (fr)
      8'h00: g = 17'sd32768;
      8'h01: g = 17'sd30929;
      8'h02: g = 17'sd29193;
      8'h03: g = 17'sd27554;
      8'h04: g = 17'sd26008;
      8'h05: g = 17'sd24548;
      8'h06: g = 17'sd23170;
      8'h07: g = 17'sd21870;
      8'h08: g = 17'sd20643;
      8'h09: g = 17'sd19484;
      8'h0A: g = 17'sd18390;
      default: g = 17'sd17358;
    endcase
    p = 34'(x * g);
    p = (p >>> COEF_SH) >>> oct;
    if (idx >= MUTE_IDX) return '0;
    else return p[DW-1:0];
  endfunction : vol_apply

  dpev_coef_t coef_q [NCOEF]; // Coefficient store, both channels.
  dpev_st_e st_q; // Sequencer state.
  logic [2:0] act_q; // Active switches: 3D, effects, de-emphasis.
  logic [2:0] req; // Requested switches.
  logic clr; // Filter history clear while switching.
  logic half_q; // Toggles each sample for the slow rate.
  logic adv; // A volume step may be taken now.
  logic [6:0] vt_q [2]; // Requested volume per channel.
  logic [7:0] va_q [2]; // Applied volume per channel.
  logic [7:0] tgt [2]; // Volume being stepped toward.
  logic [7:0] va_d [2]; // Next applied volume.
  logic mute_s [2]; // Per-channel mute.
  dpev_smp_t in_s [2]; // Raw input samples.
  dpev_smp_t de_s [2]; // De-emphasis outputs.
  dpev_smp_t a_s [2]; // After optional de-emphasis.
  dpev_smp_t bin_s [2]; // Input to the effects chain.
  dpev_smp_t b1_s [2]; // First biquad outputs.
  dpev_smp_t b2_s [2]; // Second biquad outputs.
  dpev_smp_t e_s [2]; // After optional effects.
  dpev_smp_t p_s [2]; // After optional 3D mix.
  dpev_smp_t v_s [2]; // After volume.
  dpev_smp_t mono; // Half-sum of both channels.
  logic signed [39:0] tap; // Attenuated 3D component.
  dpev_smp_t dly_q [2][DLY]; // Sample delay line before upsampling.
  dpev_smp_t out_q [2]; // Upsampled output values.
  logic [15:0] div_q; // Output tick divider.
  logic tick; // Output tick.
  logic valid_q; // Output strobe register.
  logic done_q; // Volume settled flag.
  logic pd_q; // Power-down complete flag.

  assign in_s[0] = lnk.smp_l;
  assign in_s[1] = lnk.smp_r;
  assign mute_s[0] = lnk.mute_l;
  assign mute_s[1] = lnk.mute_r;
  assign req = {lnk.en_3d, lnk.en_eff, lnk.en_deemph};
  assign clr = (st_q == ST_APPLY);
  assign adv = lnk.smp_valid && (!lnk.slow_step || half_q);
  // The 3D mix is taken before the effects filters.
  assign mono = dpev_sat((40'(a_s[0]) + 40'(a_s[1])) >>> 1);
  // The mono path runs through the left chain, scaled by att_3d / 256.
  assign tap = (40'(e_s[0]) * $signed({1'b0, lnk.att_3d})) >>> 8;

  // Coefficient store, loaded with the default response at reset.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NCOEF; i++) begin
      if (rst) begin
        coef_q[i] <= dpev_coef_rst(5'(i));
      end else if (lnk.coef_wr && lnk.coef_addr == 5'(i)) begin
        coef_q[i] <= lnk.coef_data;
      end
    end
  end

  // Per-channel datapath.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam logic [4:0] B = 5'(c * COEF_CH); // Channel slot base.

    // First-order de-emphasis: no second-order terms, no doubling.
    dpev_sos u_de (
      .sys_clk(sys_clk),
      .rst(rst),
      .smp(lnk.smp_valid),
      .clr(clr),
      .dbl(1'b0),
      .x(in_s[c]),
      .n0(coef_q[B + K_DE_N0]),
      .n1(coef_q[B + K_DE_N1]),
      .n2('0),
      .d1(coef_q[B + K_DE_D1]),
      .d2('0),
      .y(de_s[c])
    );
    assign a_s[c] = act_q[0] ? de_s[c] : in_s[c];
    assign bin_s[c] = (act_q[2] && c == 0) ? mono : a_s[c];

    // First effects biquad.
    dpev_sos u_b1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .smp(lnk.smp_valid),
      .clr(clr),
      .dbl(1'b1),
      .x(bin_s[c]),
      .n0(coef_q[B + K_B1_N0]),
      .n1(coef_q[B + K_B1_N1]),
      .n2(coef_q[B + K_B1_N2]),
      .d1(coef_q[B + K_B1_D1]),
      .d2(coef_q[B + K_B1_D2]),
      .y(b1_s[c])
    );

    // Second effects biquad, cascaded.
    dpev_sos u_b2 (
      .sys_clk(sys_clk),
      .rst(rst),
      .smp(lnk.smp_valid),
      .clr(clr),
      .dbl(1'b1),
      .x(b1_s[c]),
      .n0(coef_q[B + K_B2_N3]),
      .n1(coef_q[B + K_B2_N4]),
      .n2(coef_q[B + K_B2_N5]),
      .d1(coef_q[B + K_B2_D4]),
      .d2(coef_q[B + K_B2_D5]),
      .y(b2_s[c])
    );

    assign e_s[c] = act_q[1] ? b2_s[c] : bin_s[c];
    assign p_s[c] = act_q[2] ? dpev_sat(40'(a_s[c]) + tap) : e_s[c];
    assign v_s[c] = vol_apply(p_s[c], va_q[c]);
    // Silence while muted, powered off or while switching processing.
    assign tgt[c] = (mute_s[c] || !lnk.dac_power || st_q != ST_RUN) ?
                    MUTE_IDX : {1'b0, vt_q[c]};
    // Step one index toward the target, or jump when stepping is off.
    assign va_d[c] = lnk.soft_off ? tgt[c] :
                     !adv ? va_q[c] :
                     (va_q[c] < tgt[c]) ? va_q[c] + 8'h01 :
                     (va_q[c] > tgt[c]) ? va_q[c] - 8'h01 : va_q[c];
  end

  // Volume targets and applied levels; reset starts fully muted.
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        vt_q[c] <= '0;
        va_q[c] <= MUTE_IDX;
      end else begin
        if (lnk.vol_wr && lnk.vol_sel[c]) begin
          vt_q[c] <= lnk.vol_val;
        end
        va_q[c] <= va_d[c];
      end
    end
  end

  // Sample parity for the slow stepping rate.
  always_ff @(posedge sys_clk) begin
    if (rst) half_q <= 1'b0;
    else if (lnk.smp_valid) half_q <= !half_q;
  end

  // Switch sequencer: fade out, change processing, fade back in.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_RUN;
      act_q <= '0;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (req != act_q) st_q <= ST_FADE;
        end
        ST_FADE: begin
          if (va_q[0] == MUTE_IDX && va_q[1] == MUTE_IDX) st_q <= ST_APPLY;
        end
        ST_APPLY: begin
          act_q <= req;
          st_q <= ST_RUN;
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // Status flags toward the host.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      done_q <= (va_q[0] == tgt[0]) && (va_q[1] == tgt[1]);
      pd_q <= !lnk.dac_power && va_q[0] == MUTE_IDX && va_q[1] == MUTE_IDX;
    end
  end
  assign lnk.vol_done = done_q;
  assign lnk.pwr_down_done = pd_q;

  // Fixed delay line: every sample waits the same number of periods.
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      // The head takes the new sample; no stage ever indexes below zero.
      if (rst) dly_q[c][0] <= '0;
      else if (lnk.smp_valid) dly_q[c][0] <= v_s[c];
      for (int i = 1; i < DLY; i++) begin
        if (rst) dly_q[c][i] <= '0;
        else if (lnk.smp_valid) dly_q[c][i] <= dly_q[c][i-1];
      end
    end
  end

  // Output tick at 128 times the reference rate.
  assign tick = (div_q == 16'(OUT_DIV - 1));
  always_ff @(posedge sys_clk) begin
    if (rst || tick) div_q <= '0;
    else div_q <= div_q + 16'h0001;
  end

  // One-pole smoothing between held samples softens upsampling images.
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) out_q[c] <= '0;
      else if (tick) out_q[c] <= dpev_sat(40'(out_q[c]) +
                          ((40'(dly_q[c][DLY-1]) - 40'(out_q[c])) >>> SMOOTH_SH));
    end
    if (rst) valid_q <= 1'b0;
    else valid_q <= tick;
  end
  assign dac_valid = valid_q;
  assign dac_l = out_q[0];
  assign dac_r = out_q[1];
endmodule : dpev_dev

/* File: design/dpev_host.sv */
// Purpose: Host end: Avalon-MM register slave that drives the playback link.
// Assumes: Waitrequest is high at rest; each access is answered in one cycle.
// Notes: Unmapped reads return zero, unmapped writes are ignored.
`timescale 1ns/1ps
module dpev_host (
  dpev_if.host lnk,
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import dpev_pkg::*;
  logic wait_q; // Waitrequest register.
  logic [31:0] rd_q; // Read data register.
  logic [31:0] ctrl_q; // Control register.
  logic smp_q, coef_q, vol_q; // Strobe registers.
  logic [31:0] wd_q; // Last written payload.
  logic acc; // Access taken this cycle.
  logic wr_ctrl, wr_vol, wr_coef, wr_smp; // Write decodes.
  logic [31:0] rd_d; // Read mux.

  assign acc = (avs_read || avs_write) && wait_q;
  assign wr_ctrl = acc && avs_write && avs_address == REG_CTRL;
  assign wr_vol = acc && avs_write && avs_address == REG_VOL;
  assign wr_coef = acc && avs_write && avs_address == REG_COEF;
  assign wr_smp = acc && avs_write && avs_address == REG_SAMPLE;
  assign rd_d = (avs_address == REG_CTRL) ? ctrl_q :
                (avs_address == REG_STATUS) ? {30'h0, lnk.pwr_down_done, lnk.vol_done} :
                32'h0000_0000;

  // Bus handshake: drop waitrequest for one cycle per access.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rd_q <= '0;
    end else begin
      wait_q <= !acc;
      if (acc && avs_read) rd_q <= rd_d;
    end
  end

  // Registers and link strobes; a volume write with both selects is master.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      wd_q <= '0;
      smp_q <= 1'b0;
      coef_q <= 1'b0;
      vol_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= avs_writedata;
      if (wr_vol || wr_coef || wr_smp) wd_q <= avs_writedata;
      smp_q <= wr_smp;
      coef_q <= wr_coef;
      vol_q <= wr_vol;
    end
  end

  // Software must clear the effects enables before loading coefficients.
  assign lnk.en_deemph = ctrl_q[CB_DEEMPH];
  assign lnk.en_eff = ctrl_q[CB_EFF];
  assign lnk.en_3d = ctrl_q[CB_3D];
  assign lnk.soft_off = ctrl_q[CB_SOFTOFF];
  assign lnk.slow_step = ctrl_q[CB_SLOW];
  assign lnk.dac_power = ctrl_q[CB_POWER];
  assign lnk.mute_l = ctrl_q[CB_MUTEL];
  assign lnk.mute_r = ctrl_q[CB_MUTER];
  assign lnk.att_3d = ctrl_q[CB_ATT +: 8];
  assign lnk.smp_valid = smp_q;
  assign lnk.smp_l = wd_q[15:0];
  assign lnk.smp_r = wd_q[31:16];
  assign lnk.coef_wr = coef_q;
  assign lnk.coef_addr = wd_q[20:16];
  assign lnk.coef_data = wd_q[15:0];
  assign lnk.vol_wr = vol_q;
  assign lnk.vol_sel = wd_q[9:8];
  assign lnk.vol_val = wd_q[6:0];
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rd_q;
endmodule : dpev_host

/* File: test/dpev_chk.sv */
// Purpose: Checker on the link between host end and playback path.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Sees only link signals, instantiated beside the interface.
`timescale 1ns/1ps
module dpev_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smp_valid,
  input wire logic coef_wr,
  input wire logic vol_wr,
  input wire logic soft_off,
  input wire logic dac_power,
  input wire logic mute_l,
  input wire logic mute_r,
  input wire logic vol_done,
  input wire logic pwr_down_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // A sample strobe was seen within the last five edges.
  sequence s_recent_smp;
    $past(smp_valid, 1) || $past(smp_valid, 2) || $past(smp_valid, 3) ||
    $past(smp_valid, 4) || $past(smp_valid, 5);
  endsequence
  a_smp_pulse: assert property (smp_valid |=> !smp_valid)
    else $error("sample strobe held");
  a_coef_pulse: assert property (coef_wr |=> !coef_wr)
    else $error("coefficient strobe held");
  a_vol_pulse: assert property (vol_wr |=> !vol_wr)
    else $error("volume strobe held");
  a_pdd_power: assert property (
    dac_power && $past(dac_power) |-> !pwr_down_done)
    else $error("power-down flag while powered");
  a_up_from_mute: assert property (
    $rose(dac_power) && !soft_off && !mute_l && !mute_r |-> ##[1:6] !vol_done)
    else $error("power-up did not start muted");
  a_jump_done: assert property (
    vol_wr && soft_off && dac_power |-> ##[1:6] vol_done)
    else $error("volume did not jump");
  a_step_paced: assert property (
    $rose(vol_done) && dac_power && !soft_off |-> s_recent_smp)
    else $error("volume settled without a sample");
  a_fade_down: assert property (
    $fell(dac_power) && !soft_off && vol_done && !mute_l && !mute_r
    |-> !pwr_down_done [*3])
    else $error("power-down skipped the fade");
endmodule : dpev_chk

/* File: test/dac_playback_effects_volume_tb.sv */
// Purpose: Self-checking bench for host end and playback path.
// Assumes: Output tick shortened to 4 clocks.
// Notes: Outputs are checked after the path settles on a constant input.
`timescale 1ns/1ps
module dac_playback_effects_volume_tb;
  import dpev_pkg::*;
  logic sys_clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dac_valid;
  dpev_smp_t dac_l;
  dpev_smp_t dac_r;
  logic [31:0] rd_q; // Last read data.
  int n_fail;
  int num_checks;
  int gap; // Clocks between two output ticks.
  // Left gets a half-gain set, right the 32 kHz set.
  logic [4:0] cf_a [6] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h11, 5'h12};
  logic [15:0] cf_v [6] = '{16'h4000, 16'h0, 16'h0, 16'h4236, 16'hFB3C, 16'h428D};
  dpev_if lnk_if ();
  dpev_host dpev_host_inst (.lnk(lnk_if.host), .sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dpev_dev #(.OUT_DIV(4)) dpev_dev_inst (.lnk(lnk_if.dev), .sys_clk(sys_clk), .rst(rst),
    .dac_valid(dac_valid), .dac_l(dac_l), .dac_r(dac_r));
  dpev_chk dpev_chk_inst (.sys_clk(sys_clk), .rst(rst), .smp_valid(lnk_if.smp_valid),
    .coef_wr(lnk_if.coef_wr), .vol_wr(lnk_if.vol_wr), .soft_off(lnk_if.soft_off),
    .dac_power(lnk_if.dac_power), .mute_l(lnk_if.mute_l), .mute_r(lnk_if.mute_r),
    .vol_done(lnk_if.vol_done), .pwr_down_done(lnk_if.pwr_down_done));
  // Clock of 5 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Holds one request until waitrequest is seen low, then releases it.
  // Only the watchdog ends a wait that never sees waitrequest low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  // Compares within a tolerance, unknown bits never match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    int d;
    d = $signed(got) - $signed(exp);
    num_checks++;
    if ((^got === 1'bx) || d > tol || d < -tol) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Sends n identical stereo samples.
  task automatic feed(input int n, input logic [15:0] l, input logic [15:0] r);
    for (int i = 0; i < n; i++) begin
      bus(1'b1, REG_SAMPLE, {r, l});
    end
  endtask : feed
  // Reads status after the flags have had time to update.
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd_q & m, e, 0);
  endtask : st
  // Checks both settled output samples.
  task automatic out(input logic [15:0] l, input logic [15:0] r);
    chk({{16{dac_l[15]}}, dac_l}, {{16{l[15]}}, l}, 16);
    chk({{16{dac_r[15]}}, dac_r}, {{16{r[15]}}, r}, 16);
  endtask : out
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // Tests need about 4000 cycles, so 60000 means a hang.
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
  // Main sequence.
  initial begin
    rst = 1'b1;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd_q, CTRL_RST, 0);
    st(32'h2, 32'h2);
    bus(1'b1, 5'h18, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd_q, 32'h0, 0);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd_q, CTRL_RST, 0);
    chk(32'(REF_HZ >= 39_000 && REF_HZ <= 53_000), 32'h1, 0);
    // Output ticks must come every OUT_DIV clocks, here 4.
    @(posedge sys_clk iff dac_valid);
    gap = 0;
    do begin
      @(posedge sys_clk);
      gap++;
    end while (dac_valid !== 1'b1);
    chk(gap, 32'h4, 0);
    $display("reset and map test done");
    bus(1'b1, REG_VOL, 32'h300);
    bus(1'b1, REG_CTRL, 32'h28);
    feed(60, 16'h4000, 16'h4000);
    out(16'h4000, 16'h4000);
    bus(1'b1, REG_VOL, 32'h10C);
    st(32'h1, 32'h1);
    feed(18, 16'h4000, 16'h4000);
    out(16'h4000, 16'h4000);
    feed(60, 16'h4000, 16'h4000);
    out(16'h2000, 16'h4000);
    bus(1'b1, REG_VOL, 32'h318);
    feed(60, 16'h4000, 16'h4000);
    out(16'h1000, 16'h1000);
    bus(1'b1, REG_CTRL, 32'h68);
    feed(60, 16'h4000, 16'h4000);
    out(16'h0000, 16'h1000);
    $display("volume test done");
    bus(1'b1, REG_VOL, 32'h300);
    bus(1'b1, REG_CTRL, 32'h29);
    feed(60, 16'h4000, 16'h4000);
    out(16'h4000, 16'h4000);
    bus(1'b1, REG_CTRL, 32'h28);
    for (int k = 0; k < 6; k++) bus(1'b1, REG_COEF, {11'h0, cf_a[k], cf_v[k]});
    bus(1'b1, REG_CTRL, 32'h29);
    feed(60, 16'h4000, 16'h4000);
    out(16'h2000, 16'h4000);
    $display("de-emphasis test done");
    bus(1'b1, REG_CTRL, 32'h802C);
    feed(60, 16'h2000, 16'h0000);
    out(16'h2800, 16'h0800);
    bus(1'b1, REG_CTRL, 32'h28);
    for (int k = 3; k < 13; k++) begin
      bus(1'b1, REG_COEF, {11'h0, 5'(k), (k == 3 || k == 8) ? 16'h4000 : 16'h0});
    end
    bus(1'b1, REG_CTRL, 32'h2A);
    feed(60, 16'h4000, 16'h4000);
    chk({{16{dac_l[15]}}, dac_l}, 32'h1000, 16);
    bus(1'b1, REG_CTRL, 32'h28);
    feed(60, 16'h4000, 16'h4000);
    out(16'h4000, 16'h4000);
    $display("3D and effects test done");
    bus(1'b1, REG_CTRL, 32'h20);
    bus(1'b1, REG_VOL, 32'h30A);
    st(32'h1, 32'h0);
    feed(5, 16'h4000, 16'h4000);
    st(32'h1, 32'h0);
    feed(8, 16'h4000, 16'h4000);
    st(32'h1, 32'h1);
    bus(1'b1, REG_CTRL, 32'h30);
    bus(1'b1, REG_VOL, 32'h300);
    feed(14, 16'h4000, 16'h4000);
    st(32'h1, 32'h0);
    feed(10, 16'h4000, 16'h4000);
    st(32'h1, 32'h1);
    $display("soft-step test done");
    bus(1'b1, REG_CTRL, 32'h22);
    st(32'h1, 32'h0);
    feed(200, 16'h4000, 16'h4000);
    st(32'h1, 32'h0);
    feed(100, 16'h4000, 16'h4000);
    st(32'h1, 32'h1);
    bus(1'b1, REG_CTRL, 32'h02);
    st(32'h2, 32'h0);
    feed(100, 16'h4000, 16'h4000);
    st(32'h2, 32'h0);
    feed(60, 16'h4000, 16'h4000);
    st(32'h2, 32'h2);
    bus(1'b1, REG_CTRL, 32'h22);
    st(32'h1, 32'h0);
    feed(140, 16'h4000, 16'h4000);
    st(32'h1, 32'h1);
    $display("fade and power test done");
    complete_run();
  end
endmodule : dac_playback_effects_volume_tb
